/* File: src/rivm_pkg.sv */
package rivm_pkg;
    localparam int RIVM_ADDR_W = 16;
    localparam int RIVM_NUM_IRQ = 30;
    localparam int RIVM_IDX_W = 5;
    // Vector addresses in program words
    localparam logic [15:0] RIVM_RESET_ADDR = 16'h0000;
    localparam logic [15:0] RIVM_TABLE_BASE = 16'h0002;
    localparam logic [15:0] RIVM_VEC_STEP = 16'h0002;
    localparam logic [15:0] RIVM_LAST_VEC = 16'h003C;
    localparam logic [15:0] RIVM_VEC_START_APP = 16'h0001;
    localparam logic [15:0] RIVM_VEC_START_BOOT_OFS = 16'h0002;
    localparam logic [15:0] RIVM_BOOT_RESET_DEF = 16'h0C00;
    localparam logic RIVM_FUSE_PROGRAMMED = 1'b0;
    // Request bit positions (bit n maps to vector n+2)
    localparam int RIVM_IRQ_ACMP0 = 0;
    localparam int RIVM_IRQ_POWER_STAGE_FAULT_REQUEST = 4;
    localparam int RIVM_IRQ_POWER_STAGE_CYCLE_END_REQUEST = 5;
    localparam int RIVM_IRQ_EXT0 = 6;
    localparam int RIVM_IRQ_WTMR_CAPT = 10;
    localparam int RIVM_IRQ_NTMR_CMPA = 14;
    localparam int RIVM_IRQ_CAN = 17;
    localparam int RIVM_IRQ_LIN_TC = 19;
    localparam int RIVM_IRQ_PIN_CHANGE_REQUEST_0 = 21;
    localparam int RIVM_IRQ_SPI = 25;
    localparam int RIVM_IRQ_ADC = 26;
    localparam int RIVM_IRQ_WDOG = 27;
    localparam int RIVM_IRQ_EEPROM = 28;
    localparam int RIVM_IRQ_PSTORE = 29;
    localparam logic [15:0] RIVM_PC_RESET = 16'h0000;
endpackage

/* File: src/rivm_vector_map.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1 - Vector 1 at 0x0000; every reset cause starts there unless fuse redirects.
// RULE2 - Comparator requests 0..3 dispatch to 0x0002, 0x0004, 0x0006, 0x0008.
// RULE3 - Power stage fault to 0x000A, cycle end to 0x000C.
// RULE4 - External requests 0..3 dispatch to 0x000E through 0x0014.
// RULE5 - Wide timer capture, compare A, compare B, overflow: 0x0016..0x001C.
// RULE6 - Narrow timer compare A, compare B, overflow: 0x001E..0x0022.
// RULE7 - CAN 0x0024, CAN timer overflow 0x0026, LIN done 0x0028, error 0x002A.
// RULE8 - Pin change requests 0..3 dispatch to 0x002C through 0x0032.
// RULE9 - SPI transfer complete to 0x0034, conversion complete to 0x0036.
// RULE10 - Watchdog 0x0038, EEPROM ready 0x003A, program store ready 0x003C.
// RULE11 - Programmed boot fuse (0) moves reset to boot reset address.
// RULE12 - Select bit set adds boot section start to each interrupt vector.
// RULE13 - Table starts at 0x001, or boot reset address plus 0x002.
// RULE14 - Software may reuse vector slots it never uses.
// RULE15 - Lowest vector address among pending enabled requests is serviced first.
module rivm_vector_map
    import rivm_pkg::*;
#(
    parameter int NUM_IRQ = RIVM_NUM_IRQ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic boot_reset_select_fuse,
    input wire logic vector_table_select_bit,
    input wire logic [RIVM_ADDR_W-1:0] boot_reset_addr,
    input wire logic [NUM_IRQ-1:0] irq_request,
    input wire logic irq_global_enable,
    input wire logic vector_ack,
    output logic vector_valid,
    output logic vector_is_reset,
    output logic [RIVM_IDX_W-1:0] vector_source,
    output logic [RIVM_ADDR_W-1:0] vector_addr,
    output logic [RIVM_ADDR_W-1:0] reset_addr,
    output logic [RIVM_ADDR_W-1:0] vector_table_start
);

    // The slot table is fixed by the vector map, so other sizes are refused
    if (NUM_IRQ != RIVM_NUM_IRQ) begin : g_bad_num_irq
        $error("rivm_vector_map: NUM_IRQ must match the vector table");
    end
    if (RIVM_TABLE_BASE + RIVM_VEC_STEP * (RIVM_NUM_IRQ - 1)
            != RIVM_LAST_VEC) begin : g_bad_last_slot
        $error("rivm_vector_map: last slot must be the final vector");
    end
    if ((1 << RIVM_IDX_W) <= NUM_IRQ) begin : g_bad_idx_w
        $error("rivm_vector_map: source index too narrow");
    end

    typedef enum logic [1:0] {
        rivm_st_fuse = 2'b00,
        rivm_st_boot = 2'b01,
        rivm_st_idle = 2'b10,
        rivm_st_offer = 2'b11
    } rivm_state_type;

    // Requests and the select bit come from logic on clk
    rivm_state_type state_r;
    rivm_state_type state_nxt;
    logic fuse_meta_r;
    logic fuse_sync_r;
    logic boot_fuse_r;
    logic boot_fuse_nxt;
    logic valid_r;
    logic valid_nxt;
    logic is_reset_r;
    logic is_reset_nxt;
    logic [RIVM_IDX_W-1:0] source_r;
    logic [RIVM_IDX_W-1:0] source_nxt;
    logic [RIVM_ADDR_W-1:0] addr_r;
    logic [RIVM_ADDR_W-1:0] addr_nxt;
    logic [RIVM_ADDR_W-1:0] reset_vec;
    logic [RIVM_ADDR_W-1:0] table_start;
    logic [RIVM_ADDR_W-1:0] irq_base;
    logic [RIVM_ADDR_W-1:0] slot_ofs [NUM_IRQ];
    logic [RIVM_IDX_W-1:0] win_idx;
    logic win_hit;

    // The fuse comes from outside the clock domain. These two flops carry
    // no reset so that they follow the fuse while reset is held; the value
    // has settled long before the state machine captures it.
    always_ff @(posedge clk) begin
        if (clk_en) begin
            fuse_meta_r <= boot_reset_select_fuse;
            fuse_sync_r <= fuse_meta_r;
        end
    end

    always_comb begin
        reset_vec = RIVM_RESET_ADDR; // RULE1
        if (boot_fuse_r == RIVM_FUSE_PROGRAMMED) begin
            reset_vec = boot_reset_addr; // RULE11
        end
        if (vector_table_select_bit) begin
            table_start = boot_reset_addr + RIVM_VEC_START_BOOT_OFS; // RULE13
            irq_base = boot_reset_addr; // RULE12
        end else begin
            table_start = RIVM_VEC_START_APP; // RULE13
            irq_base = RIVM_RESET_ADDR;
        end
    end

    // Offset of every interrupt slot from the section start (irq_base), table base included
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_slot
        assign slot_ofs[g] =
            RIVM_ADDR_W'(RIVM_TABLE_BASE + RIVM_VEC_STEP * g);
    end

    // Lowest index wins, which is also the lowest vector address
    always_comb begin
        win_hit = 1'b0;
        win_idx = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_request[i]) begin
                win_hit = 1'b1; // RULE15
                win_idx = RIVM_IDX_W'(i);
            end
        end
    end

    // The fuse is caught once, one cycle after release, so a fuse that
    // moves later cannot move reset_addr away from the reset vector offered.
    // The reset vector is offered once; requests wait until it is taken.
    always_comb begin
        state_nxt = state_r;
        boot_fuse_nxt = boot_fuse_r;
        valid_nxt = valid_r;
        is_reset_nxt = is_reset_r;
        source_nxt = source_r;
        addr_nxt = addr_r;
        case (state_r)
            rivm_st_fuse: begin
                boot_fuse_nxt = fuse_sync_r;
                valid_nxt = 1'b0;
                state_nxt = rivm_st_boot;
            end
            rivm_st_boot: begin
                valid_nxt = 1'b1;
                is_reset_nxt = 1'b1;
                source_nxt = '0;
                addr_nxt = reset_vec; // RULE1 RULE11
                state_nxt = rivm_st_offer;
            end
            rivm_st_offer: begin
                // Vector stands until the core takes it
                if (vector_ack) begin
                    valid_nxt = 1'b0;
                    state_nxt = rivm_st_idle;
                end
            end
            rivm_st_idle: begin
                // Requests are not latched: the peripheral holds its flag
                if (irq_global_enable && win_hit) begin
                    valid_nxt = 1'b1;
                    is_reset_nxt = 1'b0;
                    source_nxt = win_idx; // RULE15
                    // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
                    addr_nxt = irq_base + slot_ofs[win_idx]; // RULE12
                    state_nxt = rivm_st_offer;
                end
            end
            default: begin
                valid_nxt = 1'b0;
                state_nxt = rivm_st_fuse;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= rivm_st_fuse;
            boot_fuse_r <= ~RIVM_FUSE_PROGRAMMED;
            valid_r <= 1'b0;
            is_reset_r <= 1'b0;
            source_r <= '1;
            addr_r <= RIVM_PC_RESET;
        end else if (clk_en) begin
            state_r <= state_nxt;
            boot_fuse_r <= boot_fuse_nxt;
            valid_r <= valid_nxt;
            is_reset_r <= is_reset_nxt;
            source_r <= source_nxt;
            addr_r <= addr_nxt;
        end
    end

    // The vector outputs come straight from flops; reset_addr is decoded from the caught fuse
    assign vector_valid = valid_r;
    assign vector_is_reset = is_reset_r;
    assign vector_source = source_r;
    assign vector_addr = addr_r;
    assign reset_addr = reset_vec;
    // Table start is a level view of the current placement
    assign vector_table_start = table_start;

endmodule

/* File: test/rivm_core_model.sv */
`timescale 1ns/1ps
module rivm_core_model (
    input wire logic clk,
    input wire logic vector_valid,
    output logic vector_ack
);
    int seed = 32'h7576;
    initial vector_ack = 1'b0;
    // Random stall before fetching; one-cycle take so no double fetch
    always @(posedge clk) begin
        vector_ack <= !vector_ack && vector_valid && ($random(seed) & 3) == 0;
    end
endmodule

/* File: test/rivm_vector_map_properties.sv */
`timescale 1ns/1ps
module rivm_vector_map_properties
    import rivm_pkg::*;
#(
    parameter int NUM_IRQ = RIVM_NUM_IRQ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic vector_table_select_bit,
    input wire logic irq_global_enable,
    input wire logic vector_ack,
    input wire logic vector_valid,
    input wire logic vector_is_reset,
    input wire logic [NUM_IRQ-1:0] irq_request,
    input wire logic [4:0] vector_source,
    input wire logic [15:0] boot_reset_addr,
    input wire logic [15:0] vector_addr,
    input wire logic [15:0] reset_addr,
    input wire logic [15:0] vector_table_start
);
    function automatic logic [4:0] lo(logic [NUM_IRQ-1:0] r);
        lo = 5'h1F;
        for (int i = NUM_IRQ - 1; i >= 0; i--) if (r[i]) lo = 5'(i);
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_start; vector_table_start == (vector_table_select_bit ?
        boot_reset_addr + 16'h0002 : 16'h0001); endproperty
    property p_irq; vector_valid && !vector_is_reset |-> vector_addr ==
        16'h0002 + {vector_source, 1'b0} +
        (vector_table_select_bit ? boot_reset_addr : 16'h0000); endproperty
    property p_rst; vector_valid && vector_is_reset |->
        vector_addr == reset_addr; endproperty
    property p_sel; reset_addr == 16'h0000 ||
        reset_addr == boot_reset_addr; endproperty
    property p_take; clk_en && !vector_valid && irq_global_enable &&
        |irq_request |=> vector_valid &&
        vector_source == lo($past(irq_request)); endproperty
    property p_hold; vector_valid && !vector_ack |=>
        vector_valid && $stable(vector_addr); endproperty
    property p_drop; vector_valid && vector_ack && clk_en |=>
        !vector_valid; endproperty
    property p_ref; !vector_valid && !irq_global_enable |=>
        !vector_valid || vector_is_reset; endproperty
    a_start: assert property (p_start) else $error("start");
    a_irq: assert property (p_irq) else $error("vector");
    a_rst: assert property (p_rst) else $error("reset vector");
    a_sel: assert property (p_sel) else $error("reset addr");
    a_take: assert property (p_take) else $error("priority");
    a_hold: assert property (p_hold) else $error("hold");
    a_drop: assert property (p_drop) else $error("drop");
    a_ref: assert property (p_ref) else $error("refuse");
    c_rst: cover property (vector_valid && vector_is_reset && vector_ack);
    c_boot: cover property (vector_valid && vector_table_select_bit);
    c_stall: cover property (vector_valid && !vector_ack ##1 vector_valid);
endmodule

/* File: test/tb_reset_interrupt_vector_map.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, (e), (a)); end end
module tb_reset_interrupt_vector_map;
    import rivm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, vector_ack;
    logic boot_reset_select_fuse = 1'b1, vector_table_select_bit = 1'b0;
    logic irq_global_enable = 1'b0, vector_valid, vector_is_reset;
    logic [15:0] boot_reset_addr = 16'h0C00, vector_addr, reset_addr;
    logic [15:0] vector_table_start, off;
    logic [29:0] irq_request = 30'h0;
    logic [4:0] vector_source;
    int fails = 0, cmp_count = 0, seed = 32'h7576, lo;
    rivm_vector_map dut (.*);
    rivm_core_model core (.*);
    always #5 clk = ~clk;
    always @(posedge clk) clk_en <= ($random(seed) & 7) != 0;
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wait_ack;
        repeat (300) begin
            @(posedge clk);
            if (vector_valid === 1'b1 && vector_ack === 1'b1 &&
                clk_en === 1'b1) return;
        end
        fails++;
    endtask
    task automatic drain;
        off = vector_table_select_bit ? boot_reset_addr : 16'h0000;
        while (irq_request != 30'h0) begin
            wait_ack;
            lo = 0;
            while (!irq_request[lo]) lo++;
        `CHK("src", 5'(lo), vector_source)
        `CHK("vec", 16'(2 * lo + 2), vector_addr - off)
        `CHK("abs", off + 16'(2 * lo + 2), vector_addr)
        `CHK("num", 16'(lo + 2), (vector_addr - off) / 2 + 16'h0001)
        `CHK("tbl", vector_table_select_bit ? boot_reset_addr + 16'h0002 : 16'h0001, vector_table_start)
            irq_request[lo] <= 1'b0;
            @(posedge clk);
        end
    endtask
    initial begin
        for (int f = 1; f >= 0; f--) begin
            reset_n <= 1'b0;
            boot_reset_select_fuse <= f[0];
            boot_reset_addr <= 16'($random(seed)) & 16'h7F00;
            repeat (12) @(posedge clk);
            reset_n <= 1'b1;
            wait_ack;
        `CHK("rst", f ? 16'h0000 : boot_reset_addr, vector_addr)
        `CHK("is_rst", 1'b1, vector_is_reset)
        `CHK("rst_addr", f ? 16'h0000 : boot_reset_addr, reset_addr)
            for (int s = 0; s < 6; s++) begin
                vector_table_select_bit <= s[0];
                irq_request <= s < 2 ? 30'h3FFFFFFF : 30'($random(seed));
                repeat (3) @(posedge clk);
                `CHK("refused", 1'b0, vector_valid)
                irq_global_enable <= 1'b1;
                drain;
                irq_global_enable <= 1'b0;
                repeat (2) @(posedge clk);
            end
        end
        complete_run;
    end
    initial begin
        #400000;
        fails++;
        complete_run;
    end
endmodule
bind rivm_vector_map rivm_vector_map_properties #(.NUM_IRQ(NUM_IRQ)) chk (.*);
